// ==== core/srsv_pkg.sv ====
package srsv_pkg;

    // register byte offsets on the AXI4-Lite port
    localparam logic [7:0] OFF_RX_STATUS = 8'h00;
    localparam logic [7:0] OFF_RX_DATA = 8'h04;
    localparam logic [7:0] OFF_VEC_READ = 8'h08;
    localparam logic [7:0] OFF_VEC_CTRL = 8'h0C;
    localparam logic [7:0] OFF_CONFIG = 8'h10;
    localparam logic [7:0] OFF_COMMAND = 8'h14;
    localparam logic [7:0] OFF_FILL = 8'h18;

    // reset values
    localparam logic [7:0] VEC_CTRL_RST = 8'h00;
    localparam logic [11:0] CONFIG_RST = 12'h000;

    // config field positions
    localparam int CFG_MODE_LO = 0;
    localparam int CFG_LEN_LO = 2;
    localparam int CFG_PAR_EN = 4;
    localparam int CFG_PAR_ODD = 5;
    localparam int CFG_PAR_SPECIAL = 6;
    localparam int CFG_RX_INT_EN = 7;
    localparam int CFG_COND_VEC = 8;
    localparam int CFG_VEC_LOW = 9;
    localparam int CFG_RX_EN = 10;
    // command bit: error reset
    localparam int CMD_ERR_RESET = 0;

    // status byte bit positions
    localparam int ST_ALL_SENT = 0;
    localparam int ST_RES_LO = 1;
    localparam int ST_PARITY = 4;
    localparam int ST_OVERRUN = 5;
    localparam int ST_CRC_FRAME = 6;
    localparam int ST_END_FRAME = 7;

    // vector condition codes, channel B and idle
    localparam logic [2:0] VC_NONE = 3'h7;
    localparam logic [2:0] VC_RX_AVAIL = 3'h2;
    localparam logic [2:0] VC_SPECIAL = 3'h3;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        MODE_ASYNC = 2'h0,
        MODE_SYNC = 2'h1,
        MODE_SDLC = 2'h2
    } srsv_mode_e;

    // one character from the synchronous / sdlc framer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parity_err;
        logic crc_err;
        logic end_frame;
        logic [2:0] residue_row;
    } srsv_sync_char_s;

    // one buffered character with its own status
    typedef struct packed {
        logic [7:0] data;
        logic crc_frame;
        logic end_frame;
        logic [2:0] residue;
    } srsv_entry_s;

endpackage : srsv_pkg

// ==== core/srsv_core.sv ====
`timescale 1ns/1ps
module srsv_core #(
    parameter int CLKS_PER_BIT = 16,
    parameter int DEPTH = 3
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // line side
    input wire logic rxd,
    input wire srsv_pkg::srsv_sync_char_s sync_char,
    // transmitter state
    input wire logic tx_buffer_full,
    input wire logic tx_shift_busy,
    // condition requests
    output logic special_irq,
    output logic rx_avail_irq
);

    localparam int HALF_BIT = (CLKS_PER_BIT / 2 > 0) ? CLKS_PER_BIT / 2 : 1;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_START = 3'h1,
        RX_DATA = 3'h3,
        RX_PARITY = 3'h2,
        RX_STOP = 3'h6,
        RX_HOLD = 3'h7
    } srsv_rx_state_e;

    // residue row to code, one table per character length
    function automatic logic [2:0] residue_code(input logic [1:0] len, input logic [2:0] row);
        logic [23:0] tbl;
        tbl = 24'h000000;
        case (len)
            2'h3: tbl = {3'h0, 3'h7, 3'h3, 3'h5, 3'h1, 3'h6, 3'h2, 3'h4};
            2'h2: tbl = {3'h0, 3'h0, 3'h3, 3'h5, 3'h1, 3'h6, 3'h2, 3'h4};
            2'h1: tbl = {3'h0, 3'h0, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2, 3'h4};
            default: tbl = {3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h6, 3'h2, 3'h4};
        endcase
        residue_code = tbl[row*3 +: 3];
    endfunction : residue_code

    // parity of the low data bits for the chosen length
    function automatic logic data_parity(input logic [7:0] d, input logic [1:0] len);
        logic [7:0] mask;
        mask = 8'hFF >> (3'h3 - {1'b0, len});
        data_parity = ^(d & mask);
    endfunction : data_parity

    logic [7:0] vec_ctrl_reg;
    logic [11:0] config_reg;
    srsv_pkg::srsv_entry_s mem_reg [DEPTH];
    logic [1:0] count_reg;
    logic parity_err_reg;
    logic overrun_reg;
    logic special_reg;
    srsv_rx_state_e rx_state_reg;
    logic [15:0] rx_cnt_reg;
    logic [2:0] rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic rx_par_reg;
    logic [7:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;

    srsv_pkg::srsv_mode_e mode;
    logic [1:0] char_len;
    logic async_mode;
    logic sdlc_mode;
    logic par_en;
    logic err_reset;
    logic pop;
    logic push;
    srsv_pkg::srsv_entry_s push_entry;
    logic push_par_err;
    logic push_special;
    logic fe_detect;
    logic async_push;
    logic [7:0] status_byte;
    logic [7:0] vector_byte;
    logic [2:0] cond_code;
    logic do_write;
    logic [7:0] rd_addr;

    assign mode = srsv_pkg::srsv_mode_e'(config_reg[srsv_pkg::CFG_MODE_LO +: 2]);
    assign char_len = config_reg[srsv_pkg::CFG_LEN_LO +: 2];
    assign async_mode = (mode == srsv_pkg::MODE_ASYNC);
    assign sdlc_mode = (mode == srsv_pkg::MODE_SDLC);
    assign par_en = config_reg[srsv_pkg::CFG_PAR_EN];

    // axi write: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= srsv_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_reg == srsv_pkg::OFF_VEC_CTRL || awaddr_reg == srsv_pkg::OFF_CONFIG
                    || awaddr_reg == srsv_pkg::OFF_COMMAND) begin
                    s_axi_bresp <= srsv_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= srsv_pkg::RESP_DECERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // programmed registers; writes to read-only words are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_ctrl_reg <= srsv_pkg::VEC_CTRL_RST;
            config_reg <= srsv_pkg::CONFIG_RST;
        end else if (do_write) begin
            if (awaddr_reg == srsv_pkg::OFF_VEC_CTRL && wstrb_reg[0]) begin
                vec_ctrl_reg <= wdata_reg[7:0];
            end else if (awaddr_reg == srsv_pkg::OFF_CONFIG) begin
                if (wstrb_reg[0]) begin
                    config_reg[7:0] <= wdata_reg[7:0];
                end
                if (wstrb_reg[1]) begin
                    config_reg[11:8] <= wdata_reg[11:8];
                end
            end
        end
    end

    // error reset is a one-cycle command strobe
    assign err_reset = do_write && awaddr_reg == srsv_pkg::OFF_COMMAND && wstrb_reg[0]
        && wdata_reg[srsv_pkg::CMD_ERR_RESET];

    // axi read; reading the data word advances the buffer
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_addr = s_axi_araddr;
    assign pop = s_axi_arvalid && s_axi_arready && rd_addr == srsv_pkg::OFF_RX_DATA;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= srsv_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= srsv_pkg::RESP_OKAY;
            if (rd_addr == srsv_pkg::OFF_RX_STATUS) begin
                s_axi_rdata <= {24'h000000, status_byte};
            end else if (rd_addr == srsv_pkg::OFF_RX_DATA) begin
                s_axi_rdata <= {24'h000000, mem_reg[0].data};
            end else if (rd_addr == srsv_pkg::OFF_VEC_READ) begin
                s_axi_rdata <= {24'h000000, vector_byte};
            end else if (rd_addr == srsv_pkg::OFF_VEC_CTRL) begin
                s_axi_rdata <= {24'h000000, vec_ctrl_reg};
            end else if (rd_addr == srsv_pkg::OFF_CONFIG) begin
                s_axi_rdata <= {20'h00000, config_reg};
            end else if (rd_addr == srsv_pkg::OFF_FILL) begin
                s_axi_rdata <= {29'h00000000, special_reg, count_reg};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= srsv_pkg::RESP_DECERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // async receiver: centre sampling at half-bit offset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg <= 16'h0000;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_par_reg <= 1'b0;
        end else if (!async_mode || !config_reg[srsv_pkg::CFG_RX_EN]) begin
            rx_state_reg <= RX_IDLE;
        end else if (rx_state_reg != RX_IDLE && rx_cnt_reg != 16'h0000) begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
        end else begin
            case (rx_state_reg)
                RX_IDLE: begin
                    if (!rxd) begin
                        rx_state_reg <= RX_START;
                        rx_cnt_reg <= 16'(HALF_BIT - 1);
                    end
                end
                RX_START: begin
                    // a glitch shorter than half a bit is not a start
                    rx_state_reg <= rxd ? RX_IDLE : RX_DATA;
                    rx_cnt_reg <= 16'(CLKS_PER_BIT - 1);
                    rx_bit_reg <= 3'h0;
                    rx_shift_reg <= 8'h00;
                end
                RX_DATA: begin
                    rx_shift_reg[rx_bit_reg] <= rxd;
                    rx_bit_reg <= rx_bit_reg + 3'h1;
                    rx_cnt_reg <= 16'(CLKS_PER_BIT - 1);
                    if (rx_bit_reg == 3'h4 + {1'b0, char_len}) begin
                        rx_state_reg <= par_en ? RX_PARITY : RX_STOP;
                    end
                end
                RX_PARITY: begin
                    rx_par_reg <= rxd;
                    rx_cnt_reg <= 16'(CLKS_PER_BIT - 1);
                    rx_state_reg <= RX_STOP;
                end
                RX_STOP: begin
                    if (!rxd) begin
                        rx_state_reg <= RX_HOLD;
                        rx_cnt_reg <= 16'(HALF_BIT - 1);
                    end else begin
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    assign async_push = rx_state_reg == RX_STOP && rx_cnt_reg == 16'h0000 && async_mode
        && config_reg[srsv_pkg::CFG_RX_EN];
    assign fe_detect = async_push && !rxd;

    // merge async and framer characters into one push
    always_comb begin
        push_entry = '0;
        push_par_err = 1'b0;
        if (async_mode) begin
            push = async_push;
            push_entry.data = rx_shift_reg;
            push_entry.crc_frame = !rxd;
            push_par_err = par_en
                && (data_parity(rx_shift_reg, char_len) ^ rx_par_reg) != config_reg[srsv_pkg::CFG_PAR_ODD];
        end else begin
            push = sync_char.valid;
            push_entry.data = sync_char.data;
            push_entry.crc_frame = sync_char.crc_err;
            push_entry.end_frame = sdlc_mode && sync_char.end_frame;
            push_entry.residue = sdlc_mode && sync_char.end_frame
                ? residue_code(char_len, sync_char.residue_row) : 3'h0;
            push_par_err = par_en && sync_char.parity_err;
        end
    end

    assign push_special = push && ((push_par_err && config_reg[srsv_pkg::CFG_PAR_SPECIAL])
        || count_reg == 2'(DEPTH) && !pop || (async_mode && push_entry.crc_frame)
        || push_entry.end_frame);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 2'h0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            // entry 0 keeps the last status after the buffer drains
            if (pop && count_reg > 2'h1) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    mem_reg[i] <= mem_reg[i + 1];
                end
            end
            // error reset clears end of frame
            if (err_reset) begin
                for (int i = 0; i < DEPTH; i++) begin
                    mem_reg[i].end_frame <= 1'b0;
                end
            end
            if (push) begin
                if (count_reg == 2'(DEPTH) && !pop) begin
                    mem_reg[DEPTH - 1] <= push_entry;
                end else if (pop && count_reg != 2'h0) begin
                    mem_reg[count_reg - 2'h1] <= push_entry;
                end else begin
                    mem_reg[count_reg] <= push_entry;
                end
            end
            if (push && !(pop && count_reg != 2'h0) && count_reg != 2'(DEPTH)) begin
                count_reg <= count_reg + 2'h1;
            end else if (!push && pop && count_reg != 2'h0) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

    // latched errors; a new error beats the reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            parity_err_reg <= 1'b0;
            overrun_reg <= 1'b0;
            special_reg <= 1'b0;
        end else begin
            if (err_reset) begin
                parity_err_reg <= 1'b0;
                overrun_reg <= 1'b0;
                special_reg <= 1'b0;
            end
            if (push && push_par_err) begin
                parity_err_reg <= 1'b1;
            end
            if (push && count_reg == 2'(DEPTH) && !pop) begin
                overrun_reg <= 1'b1;
            end
            if (push_special) begin
                special_reg <= 1'b1;
            end
        end
    end

    // status byte view of the head character
    always_comb begin
        status_byte = 8'h00;
        status_byte[srsv_pkg::ST_ALL_SENT] = !async_mode || !(tx_buffer_full || tx_shift_busy);
        status_byte[srsv_pkg::ST_RES_LO +: 3] = mem_reg[0].residue;
        status_byte[srsv_pkg::ST_PARITY] = parity_err_reg;
        status_byte[srsv_pkg::ST_OVERRUN] = overrun_reg;
        status_byte[srsv_pkg::ST_CRC_FRAME] = mem_reg[0].crc_frame;
        status_byte[srsv_pkg::ST_END_FRAME] = mem_reg[0].end_frame;
    end

    // requests gated by the receive interrupt enable
    assign special_irq = special_reg && config_reg[srsv_pkg::CFG_RX_INT_EN];
    assign rx_avail_irq = count_reg != 2'h0 && config_reg[srsv_pkg::CFG_RX_INT_EN];

    always_comb begin
        if (special_irq) begin
            cond_code = srsv_pkg::VC_SPECIAL;
        end else if (rx_avail_irq) begin
            cond_code = srsv_pkg::VC_RX_AVAIL;
        end else begin
            cond_code = srsv_pkg::VC_NONE;
        end
        vector_byte = vec_ctrl_reg;
        if (config_reg[srsv_pkg::CFG_COND_VEC]) begin
            if (config_reg[srsv_pkg::CFG_VEC_LOW]) begin
                vector_byte[2:0] = cond_code;
            end else begin
                vector_byte[4:2] = cond_code;
            end
        end
    end

    // checks
    property p_all_sent_sync;
        @(posedge aclk) disable iff (!aresetn)
        !async_mode |-> status_byte[0];
    endproperty
    a_all_sent_sync: assert property (p_all_sent_sync) else $error("all sent low in sync");

    property p_all_sent_async;
        @(posedge aclk) disable iff (!aresetn)
        async_mode && (tx_buffer_full || tx_shift_busy) |-> !status_byte[0];
    endproperty
    a_all_sent_async: assert property (p_all_sent_async) else $error("all sent with busy tx");

    property p_overrun_set;
        @(posedge aclk) disable iff (!aresetn)
        push && !pop && count_reg == 2'(DEPTH) |=> overrun_reg && count_reg == 2'(DEPTH);
    endproperty
    a_overrun_set: assert property (p_overrun_set) else $error("overrun not latched");

    property p_overrun_hold;
        @(posedge aclk) disable iff (!aresetn)
        overrun_reg && !err_reset |=> overrun_reg;
    endproperty
    a_overrun_hold: assert property (p_overrun_hold) else $error("overrun dropped");

    property p_hold_after_fe;
        @(posedge aclk) disable iff (!aresetn)
        fe_detect |=> rx_state_reg == RX_HOLD && rx_cnt_reg == 16'(HALF_BIT - 1);
    endproperty
    a_hold_after_fe: assert property (p_hold_after_fe) else $error("no half bit hold");

    property p_crc_no_special;
        @(posedge aclk) disable iff (!aresetn)
        !async_mode && push && !push_entry.end_frame && !push_par_err && count_reg == 2'h0
            && !special_reg |=> !special_reg;
    endproperty
    a_crc_no_special: assert property (p_crc_no_special) else $error("crc raised special");

    property p_vector_plain;
        @(posedge aclk) disable iff (!aresetn)
        !config_reg[srsv_pkg::CFG_COND_VEC] |-> vector_byte == vec_ctrl_reg;
    endproperty
    a_vector_plain: assert property (p_vector_plain) else $error("vector altered");

    property p_vector_special;
        @(posedge aclk) disable iff (!aresetn)
        config_reg[srsv_pkg::CFG_COND_VEC] && !config_reg[srsv_pkg::CFG_VEC_LOW] && special_irq
            |-> vector_byte[4:2] == srsv_pkg::VC_SPECIAL;
    endproperty
    a_vector_special: assert property (p_vector_special) else $error("special code wrong");

    property p_eof_clear;
        @(posedge aclk) disable iff (!aresetn)
        err_reset && !push |=> !status_byte[srsv_pkg::ST_END_FRAME];
    endproperty
    a_eof_clear: assert property (p_eof_clear) else $error("end frame kept");

    c_overrun: cover property (@(posedge aclk) disable iff (!aresetn) $rose(overrun_reg));
    c_framing: cover property (@(posedge aclk) disable iff (!aresetn) fe_detect);
    c_end_frame: cover property (@(posedge aclk) disable iff (!aresetn)
        push && push_entry.end_frame);

endmodule : srsv_core

// ==== test/srsv_station.sv ====
`timescale 1ns/1ps
// far station: one async character with parity, lsb first, idle high
module srsv_station #(
    parameter int CLKS_PER_BIT = 4
) (
    // clock
    input wire logic aclk,
    // line
    output logic rxd
);
    initial rxd = 1'b1;

    // a low stop level lets the bench send a framing fault
    task automatic send(input logic [7:0] d, input logic par, input logic stop);
        logic [10:0] bits;
        bits = {stop, par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= bits[i];
            repeat (CLKS_PER_BIT) @(posedge aclk);
        end
        rxd <= 1'b1;
        repeat (2 * CLKS_PER_BIT) @(posedge aclk);
    endtask : send
endmodule : srsv_station

// ==== test/srsv_core_test.sv ====
`timescale 1ns/1ps
module srsv_core_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic tx_full = 1'b0;
    logic tx_busy = 1'b0;
    logic bready = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp;
    logic [1:0] wresp = 2'h0;
    srsv_pkg::srsv_sync_char_s sync_char = '0;
    logic awready, wready, bvalid, arready, rvalid, special_irq, rx_avail_irq, rxd;
    logic [1:0] rresp;
    logic [31:0] rdata;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] burst [4] = '{8'h11, 8'h22, 8'h33, 8'h44};

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    // response readies raised per transfer and dropped once the answer is taken
    srsv_core #(.CLKS_PER_BIT(4), .DEPTH(3)) srsv_core_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rxd(rxd), .sync_char(sync_char), .tx_buffer_full(tx_full), .tx_shift_busy(tx_busy),
        .special_irq(special_irq), .rx_avail_irq(rx_avail_irq)
    );
    srsv_station #(.CLKS_PER_BIT(4)) srsv_station_inst (.aclk(aclk), .rxd(rxd));

    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // read one word and compare at the edge that takes the answer
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, exp);
    endtask : rc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        wresp = bresp;
        bready <= 1'b0;
        // one idle edge so a following write never re-drives bready in this step
        @(posedge aclk);
    endtask : wr

    // one framer character, valid for a single cycle
    task automatic sc(input logic [7:0] d, input logic crc, input logic eof, input logic [2:0] row);
        sync_char <= {1'b1, d, 1'b0, crc, eof, row};
        @(posedge aclk);
        sync_char <= '0;
        @(posedge aclk);
    endtask : sc

    // even parity; flip spoils it
    task automatic tx(input logic [7:0] d, input logic flip, input logic stop);
        srsv_station_inst.send(d, ^d ^ flip, stop);
    endtask : tx

    // hang guard, about thirty times the expected run
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(8'h10, 32'h0);
        rc(8'h1C, 32'h0);
        chk(rresp, 32'h3);
        wr(8'h0C, 32'hA5);
        rc(8'h08, 32'hA5);
        wr(8'h00, 32'hFF);
        chk(wresp, 32'h3);
        wstrb <= 4'h0;
        wr(8'h0C, 32'h5A);
        wstrb <= 4'hF;
        chk(wresp, 32'h0);
        rc(8'h0C, 32'hA5);
        tx_full <= 1'b1;
        rc(8'h00, 32'h00);
        tx_full <= 1'b0;
        rc(8'h00, 32'h01);
        tx_busy <= 1'b1;
        wr(8'h10, 32'h1);
        rc(8'h00, 32'h01);
        tx_busy <= 1'b0;
        $display("test registers done");
        wr(8'h10, 32'h7DC);
        tx(8'h5A, 1'b0, 1'b1);
        chk(rx_avail_irq, 32'h1);
        rc(8'h08, 32'hA2);
        rc(8'h00, 32'h01);
        rc(8'h04, 32'h5A);
        tx(8'h33, 1'b1, 1'b1);
        chk(special_irq, 32'h1);
        rc(8'h08, 32'hA3);
        rc(8'h00, 32'h11);
        rc(8'h04, 32'h33);
        tx(8'h0F, 1'b0, 1'b1);
        rc(8'h00, 32'h11);
        rc(8'h04, 32'h0F);
        wr(8'h14, 32'h1);
        rc(8'h00, 32'h01);
        rc(8'h08, 32'hA7);
        $display("test parity done");
        tx(8'h81, 1'b0, 1'b0);
        rc(8'h00, 32'h41);
        chk(special_irq, 32'h1);
        rc(8'h04, 32'h81);
        tx(8'h7E, 1'b0, 1'b1);
        rc(8'h00, 32'h01);
        rc(8'h04, 32'h7E);
        wr(8'h14, 32'h1);
        $display("test framing done");
        foreach (burst[i]) tx(burst[i], 1'b0, 1'b1);
        rc(8'h00, 32'h21);
        rc(8'h04, 32'h11);
        rc(8'h04, 32'h22);
        rc(8'h04, 32'h44);
        $display("test overrun done");
        wr(8'h14, 32'h1);
        wr(8'h10, 32'h18E);
        sc(8'hC3, 1'b1, 1'b0, 3'h0);
        chk(special_irq, 32'h0);
        rc(8'h00, 32'h41);
        rc(8'h08, 32'hA9);
        rc(8'h04, 32'hC3);
        sc(8'h7E, 1'b0, 1'b1, 3'h2);
        chk(special_irq, 32'h1);
        rc(8'h08, 32'hAD);
        rc(8'h00, 32'h8D);
        wr(8'h14, 32'h1);
        rc(8'h00, 32'h0D);
        wr(8'h10, 32'h18A);
        sc(8'h55, 1'b0, 1'b1, 3'h6);
        rc(8'h04, 32'h7E);
        rc(8'h00, 32'h81);
        $display("test sdlc done");
        complete_run();
    end
endmodule : srsv_core_test
